/* File: design/src_pkg.sv */
package src_pkg;

	////////////////////////////////////////////////////////////////////////
	// command codes
	localparam logic [7:0] CMD_PROTECT = 8'h21;
	localparam logic [7:0] CMD_READ_IO = 8'h15;
	localparam logic [7:0] CMD_READ_STATUS = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// negative acknowledge codes
	localparam logic [7:0] NAK_BAD_LOCKOUT = 8'h09;
	localparam logic [7:0] NAK_BUSY = 8'h01;
	localparam logic [7:0] NAK_INVALID = 8'h02;

	////////////////////////////////////////////////////////////////////////
	// protection addresses
	localparam logic [15:0] PROTECT_OFF_ADDR = 16'h0000;
	localparam logic [15:0] PROTECT_ALL_ADDR = 16'hffff;
	localparam logic [15:0] LOCKOUT_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SERVO_CYCLE_NS = 120000;
	localparam int SERVO_CYCLE_CLKS = SERVO_CYCLE_NS / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// io state word layout
	localparam int IOW_HI_LSB = 12;
	localparam int IOW_RSVD = 11;
	localparam int IOW_DELAY = 10;
	localparam int IOW_HOLD = 9;
	localparam int IOW_MOVE = 8;
	localparam int IOW_TEMP = 7;
	localparam int IOW_LO_LSB = 4;
	localparam int IOW_TRAJ = 3;
	localparam int IOW_EXT_IDX = 2;
	localparam int IOW_INT_IDX = 1;
	localparam int IOW_SEL_IDX = 0;
	// idle lines high, temperature good, nothing else
	localparam logic [15:0] IOW_RESET = 16'hf0f0;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] STATUS_LATCH_MASK = 16'h7f01;

	////////////////////////////////////////////////////////////////////////
	// reply characters
	localparam logic [7:0] CHR_SPACE = 8'h20;
	localparam logic [7:0] CHR_CR = 8'h0d;
	localparam logic [3:0] REPLY_LEN = 4'hd;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_REPLY = 2'b10
	} src_state_t;

endpackage

/* File: design/src_reply_ser.sv */
`timescale 1ns/1ns
module src_reply_ser (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] node_addr,
	input wire logic [15:0] code,
	input wire logic [15:0] data,
	output logic busy,
	output logic done,
	output logic char_valid,
	input wire logic char_ready,
	output logic [7:0] char_data
);

	logic [39:0] frame_ff;
	logic [3:0] idx_ff;
	logic active_ff;
	logic done_ff;
	logic [7:0] char_ff;
	logic [39:0] new_frame;

	////////////////////////////////////////////////////////////////////////
	// upper case hex, as the host parses it
	function automatic logic [7:0] hex_chr(input logic [3:0] nib);
		if (nib < 4'ha) begin
			hex_chr = 8'h30 + {4'h0, nib};
		end else begin
			hex_chr = 8'h37 + {4'h0, nib};
		end
	endfunction

	function automatic logic [7:0] char_at(input logic [3:0] i,
		input logic [39:0] f);
		case (i)
			4'h0: char_at = hex_chr(f[39:36]);
			4'h1: char_at = hex_chr(f[35:32]);
			4'h2: char_at = src_pkg::CHR_SPACE;
			4'h3: char_at = hex_chr(f[31:28]);
			4'h4: char_at = hex_chr(f[27:24]);
			4'h5: char_at = hex_chr(f[23:20]);
			4'h6: char_at = hex_chr(f[19:16]);
			4'h7: char_at = src_pkg::CHR_SPACE;
			4'h8: char_at = hex_chr(f[15:12]);
			4'h9: char_at = hex_chr(f[11:8]);
			4'ha: char_at = hex_chr(f[7:4]);
			4'hb: char_at = hex_chr(f[3:0]);
			default: char_at = src_pkg::CHR_CR;
		endcase
	endfunction

	assign new_frame = {node_addr, code, data};

	////////////////////////////////////////////////////////////////////////
	// character sequencing
	always_ff @(posedge clk) begin
		if (rst) begin
			frame_ff <= 40'h0;
			idx_ff <= 4'h0;
			active_ff <= 1'b0;
			char_ff <= 8'h00;
		end else if (!active_ff) begin
			if (start) begin
				frame_ff <= new_frame;
				idx_ff <= 4'h0;
				active_ff <= 1'b1;
				char_ff <= char_at(4'h0, new_frame);
			end
		end else if (char_ready) begin
			if (idx_ff == src_pkg::REPLY_LEN - 4'h1) begin
				active_ff <= 1'b0;
			end else begin
				idx_ff <= idx_ff + 4'h1;
				char_ff <= char_at(idx_ff + 4'h1, frame_ff);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= active_ff && char_ready &&
				(idx_ff == src_pkg::REPLY_LEN - 4'h1);
		end
	end

	assign busy = active_ff;
	assign done = done_ff;
	assign char_valid = active_ff;
	assign char_data = char_ff;

endmodule

/* File: design/src_cmd_top.sv */
`timescale 1ns/1ns
// Summary of operation
// - protect command, code 0x21, carries 16-bit lockout code and first address
// - io state read, code 0x15, no parameters, answers 16-bit io word
// - io state word is refreshed once per 120 us servo cycle
// - word bits 15..12 follow io lines 7..4, high idle, low triggered
// - word bits 6..4 follow io lines 3..1, unlatched, high when idle
// - bit 10 is one while the delay counter runs, zero when expired
// - bit 9 shows holding error, bit 8 moving error, both unlatched
// - bit 7 is temperature good: cleared on over-temperature, else set
// - bit 3 is one while the trajectory generator is active
// - bits 2..0 index flags, each high one servo cycle per mark
// - latched status bits stay set until the clear status command
// - internal status read, code 0x14, no parameters, answers 16-bit word
// - internal status word tracks motor conditions, latched bits cleared by clear command
// - first writable address zero disables protection and clears lockout
// - first writable address 0xffff protects the whole user space
// - lockout code mismatch while protection is on rejects protect command with nak code 9
// - protect while busy gives busy nak, settings stay unchanged
module src_cmd_top #(
	parameter int SERVO_CLKS = src_pkg::SERVO_CYCLE_CLKS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] node_addr,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_from_program,
	input wire logic [15:0] cmd_param0,
	input wire logic [15:0] cmd_param1,
	input wire logic dev_busy,
	input wire logic clear_status,
	input wire logic [7:1] io_line,
	input wire logic delay_counting,
	input wire logic hold_err,
	input wire logic move_err,
	input wire logic over_temp,
	input wire logic traj_active,
	input wire logic ext_index_pulse,
	input wire logic int_index_pulse,
	input wire logic sel_index_pulse,
	input wire logic [15:0] status_live,
	input wire logic [15:0] status_event,
	output logic rsp_valid,
	input wire logic rsp_ready,
	output logic [7:0] rsp_char,
	output logic ack_pulse,
	output logic nak_pulse,
	output logic [7:0] nak_code,
	output logic protect_en,
	output logic protect_all,
	output logic [15:0] first_writable,
	output logic servo_tick,
	output logic [15:0] io_state_word,
	output logic [15:0] internal_status_word
);

	localparam int CNT_W = $clog2(SERVO_CLKS + 1);

	src_pkg::src_state_t state_ff;
	src_pkg::src_state_t nxt_state;
	logic [CNT_W-1:0] servo_cnt_ff;
	logic tick_ff;
	logic [7:1] io_sync1_ff;
	logic [7:1] io_sync2_ff;
	logic [2:0] idx_pend_ff;
	logic [15:0] iow_ff;
	logic [15:0] status_sticky_ff;
	logic [15:0] lockout_ff;
	logic [15:0] first_wr_ff;
	logic prot_on_ff;
	logic ack_ff;
	logic nak_ff;
	logic [7:0] nak_code_ff;
	logic start_ff;
	logic [15:0] rsp_code_ff;
	logic [15:0] rsp_data_ff;
	logic ser_busy;
	logic ser_done;
	logic take;
	logic is_read;
	logic [15:0] nxt_iow;
	logic [15:0] status_now;

	////////////////////////////////////////////////////////////////////////
	// servo cycle timebase
	always_ff @(posedge clk) begin
		if (rst) begin
			servo_cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (servo_cnt_ff == CNT_W'(SERVO_CLKS - 1)) begin
			servo_cnt_ff <= '0;
			tick_ff <= 1'b1;
		end else begin
			servo_cnt_ff <= servo_cnt_ff + CNT_W'(1);
			tick_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// io pins come from outside, two stages before use
	always_ff @(posedge clk) begin
		if (rst) begin
			io_sync1_ff <= 7'h7f;
			io_sync2_ff <= 7'h7f;
		end else begin
			io_sync1_ff <= io_line;
			io_sync2_ff <= io_sync1_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// index marks are gathered within a cycle and shown for the next one;
	// a mark arriving on the tick itself is kept for the following cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			idx_pend_ff <= 3'h0;
		end else if (tick_ff) begin
			idx_pend_ff <= {ext_index_pulse, int_index_pulse,
				sel_index_pulse};
		end else begin
			idx_pend_ff <= idx_pend_ff | {ext_index_pulse,
				int_index_pulse, sel_index_pulse};
		end
	end

	always_comb begin
		nxt_iow = 16'h0000;
		nxt_iow[15:src_pkg::IOW_HI_LSB] = io_sync2_ff[7:4];
		nxt_iow[src_pkg::IOW_RSVD] = 1'b0;
		nxt_iow[src_pkg::IOW_DELAY] = delay_counting;
		nxt_iow[src_pkg::IOW_HOLD] = hold_err;
		nxt_iow[src_pkg::IOW_MOVE] = move_err;
		nxt_iow[src_pkg::IOW_TEMP] = ~over_temp;
		nxt_iow[6:src_pkg::IOW_LO_LSB] = io_sync2_ff[3:1];
		nxt_iow[src_pkg::IOW_TRAJ] = traj_active;
		nxt_iow[src_pkg::IOW_EXT_IDX] = idx_pend_ff[2];
		nxt_iow[src_pkg::IOW_INT_IDX] = idx_pend_ff[1];
		nxt_iow[src_pkg::IOW_SEL_IDX] = idx_pend_ff[0];
	end

	// one snapshot per cycle keeps reads within a cycle consistent
	always_ff @(posedge clk) begin
		if (rst) begin
			iow_ff <= src_pkg::IOW_RESET;
		end else if (tick_ff) begin
			iow_ff <= nxt_iow;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// internal status: sticky bits, a new event beats a clear
	always_ff @(posedge clk) begin
		if (rst) begin
			status_sticky_ff <= src_pkg::STATUS_RESET;
		end else if (clear_status) begin
			status_sticky_ff <= status_event &
				src_pkg::STATUS_LATCH_MASK;
		end else begin
			status_sticky_ff <= status_sticky_ff |
				(status_event & src_pkg::STATUS_LATCH_MASK);
		end
	end

	assign status_now = status_sticky_ff |
		(status_live & ~src_pkg::STATUS_LATCH_MASK);

	////////////////////////////////////////////////////////////////////////
	// command acceptance
	assign cmd_ready = (state_ff == src_pkg::ST_IDLE) && !ser_busy;
	assign take = cmd_valid && cmd_ready;
	assign is_read = (cmd_code == src_pkg::CMD_READ_IO) ||
		(cmd_code == src_pkg::CMD_READ_STATUS);

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			src_pkg::ST_IDLE: begin
				if (take && is_read && !cmd_from_program) begin
					nxt_state = src_pkg::ST_REPLY;
				end
			end
			src_pkg::ST_REPLY: begin
				if (ser_done) begin
					nxt_state = src_pkg::ST_IDLE;
				end
			end
			default: nxt_state = src_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= src_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read replies
	always_ff @(posedge clk) begin
		if (rst) begin
			start_ff <= 1'b0;
			rsp_code_ff <= 16'h0000;
			rsp_data_ff <= 16'h0000;
		end else begin
			start_ff <= 1'b0;
			if (take && is_read && !cmd_from_program) begin
				start_ff <= 1'b1;
				rsp_code_ff <= {8'h00, cmd_code};
				if (cmd_code == src_pkg::CMD_READ_IO) begin
					rsp_data_ff <= iow_ff;
				end else begin
					rsp_data_ff <= status_now;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memory protection settings
	always_ff @(posedge clk) begin
		if (rst) begin
			lockout_ff <= src_pkg::LOCKOUT_RESET;
			first_wr_ff <= src_pkg::PROTECT_OFF_ADDR;
			prot_on_ff <= 1'b0;
		end else if (take && cmd_code == src_pkg::CMD_PROTECT &&
			!dev_busy && !(prot_on_ff && cmd_param0 != lockout_ff)) begin
			first_wr_ff <= cmd_param1;
			if (cmd_param1 == src_pkg::PROTECT_OFF_ADDR) begin
				prot_on_ff <= 1'b0;
				lockout_ff <= src_pkg::LOCKOUT_RESET;
			end else begin
				prot_on_ff <= 1'b1;
				lockout_ff <= cmd_param0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// acknowledge and refusal
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_ff <= 1'b0;
			nak_ff <= 1'b0;
			nak_code_ff <= 8'h00;
		end else begin
			ack_ff <= 1'b0;
			nak_ff <= 1'b0;
			if (take) begin
				if (is_read && cmd_from_program) begin
					nak_ff <= 1'b1;
					nak_code_ff <= src_pkg::NAK_INVALID;
				end else if (cmd_code == src_pkg::CMD_PROTECT) begin
					if (dev_busy) begin
						nak_ff <= 1'b1;
						nak_code_ff <= src_pkg::NAK_BUSY;
					end else if (prot_on_ff && cmd_param0 != lockout_ff) begin
						nak_ff <= 1'b1;
						nak_code_ff <= src_pkg::NAK_BAD_LOCKOUT;
					end else begin
						ack_ff <= 1'b1;
					end
				end else if (!is_read) begin
					nak_ff <= 1'b1;
					nak_code_ff <= src_pkg::NAK_INVALID;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reply serializer
	src_reply_ser u_ser (
		.clk(clk),
		.rst(rst),
		.start(start_ff),
		.node_addr(node_addr),
		.code(rsp_code_ff),
		.data(rsp_data_ff),
		.busy(ser_busy),
		.done(ser_done),
		.char_valid(rsp_valid),
		.char_ready(rsp_ready),
		.char_data(rsp_char)
	);

	assign ack_pulse = ack_ff;
	assign nak_pulse = nak_ff;
	assign nak_code = nak_code_ff;
	assign protect_en = prot_on_ff;
	// whole user space locked when the first writable address is the top
	assign protect_all = prot_on_ff &&
		(first_wr_ff == src_pkg::PROTECT_ALL_ADDR);
	assign first_writable = first_wr_ff;
	assign servo_tick = tick_ff;
	assign io_state_word = iow_ff;
	assign internal_status_word = status_now;

endmodule

/* File: dv/src_cmd_assertions.sv */
`timescale 1ns/1ns
module src_cmd_assertions #(
	parameter int SERVO_CLKS = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_from_program,
	input wire logic [15:0] cmd_param1,
	input wire logic dev_busy,
	input wire logic clear_status,
	input wire logic [15:0] status_event,
	input wire logic rsp_valid,
	input wire logic ack_pulse,
	input wire logic nak_pulse,
	input wire logic [7:0] nak_code,
	input wire logic protect_en,
	input wire logic protect_all,
	input wire logic [15:0] first_writable,
	input wire logic servo_tick,
	input wire logic [15:0] io_state_word,
	input wire logic [15:0] internal_status_word
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic take;
	logic prot;
	logic seen_ff;
	logic [15:0] cnt_ff;
	assign take = cmd_valid && cmd_ready;
	assign prot = take && cmd_code == src_pkg::CMD_PROTECT;
	// counter instead of a long repetition, which would unroll badly
	always_ff @(posedge clk) begin
		if (rst || servo_tick) cnt_ff <= 16'h0000;
		else cnt_ff <= cnt_ff + 16'h0001;
	end
	always_ff @(posedge clk) begin
		if (rst) seen_ff <= 1'b0;
		else if (servo_tick) seen_ff <= 1'b1;
	end
	////////////////////////////////////////////////////////////////////
	a_tick_spacing: assert property (
		servo_tick && seen_ff |-> cnt_ff == 16'(SERVO_CLKS - 1))
		else $error("servo tick spacing wrong");
	a_io_steady: assert property (
		!servo_tick |=> $stable(io_state_word))
		else $error("io word changed off tick");
	a_protect_ack: assert property (
		prot && !dev_busy && !protect_en |=> ack_pulse && !nak_pulse)
		else $error("protect not acked");
	a_busy_refuse: assert property (
		prot && dev_busy |=> nak_pulse && nak_code == src_pkg::NAK_BUSY
		&& $stable(protect_en) && $stable(first_writable))
		else $error("busy protect not refused");
	a_zero_unprotect: assert property (
		prot && !dev_busy && cmd_param1 == 16'h0000
		|=> !ack_pulse || (!protect_en && first_writable == 16'h0000))
		else $error("zero address left protection on");
	a_all_flag: assert property (
		protect_all == (protect_en && first_writable == 16'hffff))
		else $error("protect all flag wrong");
	a_read_reply: assert property (
		take && !cmd_from_program && (cmd_code == src_pkg::CMD_READ_IO
		|| cmd_code == src_pkg::CMD_READ_STATUS) |-> ##2 rsp_valid)
		else $error("read reply late");
	a_program_refuse: assert property (
		take && cmd_from_program && cmd_code == src_pkg::CMD_READ_IO
		|=> nak_pulse && nak_code == src_pkg::NAK_INVALID)
		else $error("program read not refused");
	a_rsvd_zero: assert property (
		io_state_word[11] == 1'b0)
		else $error("reserved io bit set");
	a_status_clear: assert property (
		clear_status && status_event == 16'h0000
		|=> (internal_status_word & 16'h7f01) == 16'h0000)
		else $error("status not cleared");
	a_event_sticky: assert property (
		status_event[8] |=> internal_status_word[8])
		else $error("status event not latched");
	c_protect: cover property (prot && !dev_busy);
	c_read: cover property (take && cmd_code == src_pkg::CMD_READ_IO);
	c_refuse: cover property (take && cmd_from_program);
endmodule

/* File: dv/src_host.sv */
`timescale 1ns/1ns
module src_host (
	input wire logic clk,
	input wire logic cmd_ready,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_char,
	input wire logic ack_pulse,
	input wire logic nak_pulse,
	input wire logic [7:0] nak_code,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic cmd_from_program,
	output logic [15:0] cmd_param0,
	output logic [15:0] cmd_param1,
	output logic rsp_ready
);
	logic [7:0] chars[$];
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_from_program = 1'b0;
		cmd_param0 = 16'h0000;
		cmd_param1 = 16'h0000;
		rsp_ready = 1'b0;
	end
	// the sink stalls at random to stretch every reply
	always @(posedge clk) rsp_ready <= 1'($urandom_range(0, 1));
	always @(negedge clk) if (rsp_valid && rsp_ready) chars.push_back(rsp_char);
	////////////////////////////////////////////////////////////////////
	// prog set only where a refusal is wanted
	task automatic issue(input logic [7:0] code, input logic [15:0] p0,
		input logic [15:0] p1, input logic prog, output logic [8:0] res);
		int n;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= code;
		cmd_param0 <= p0;
		cmd_param1 <= p1;
		cmd_from_program <= prog;
		@(negedge clk);
		while (!cmd_ready) @(negedge clk);
		@(posedge clk);
		cmd_valid <= 1'b0;
		// released lines must not keep looking valid
		cmd_code <= ~code;
		cmd_param0 <= ~p0;
		cmd_param1 <= ~p1;
		res = 9'h000;
		for (n = 0; n < 3; n++) begin
			@(negedge clk);
			if (ack_pulse) res = 9'h100;
			if (nak_pulse) res = {1'b0, nak_code};
		end
	endtask
endmodule

/* File: dv/tb.sv */
`timescale 1ns/1ns
module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] node_addr = 8'h00;
	logic dev_busy = 1'b0;
	logic clear_status = 1'b0;
	logic [7:1] io_line = 7'h7f;
	logic [4:0] lv = 5'h00;
	logic [2:0] idx = 3'h0;
	logic [15:0] status_live = 16'h0000;
	logic [15:0] status_event = 16'h0000;
	logic cmd_valid, cmd_ready, cmd_from_program, rsp_valid, rsp_ready;
	logic ack_pulse, nak_pulse, protect_en, protect_all, servo_tick;
	logic [7:0] cmd_code, rsp_char, nak_code;
	logic [15:0] cmd_param0, cmd_param1, first_writable;
	logic [15:0] io_state_word, internal_status_word;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	logic en = 1'b0;
	logic [15:0] lock = 16'h0000;
	logic [15:0] fw = 16'h0000;
	always #10 clk = ~clk;
	src_cmd_top #(.SERVO_CLKS(8)) src_cmd_top_inst (.clk(clk), .rst(rst),
		.node_addr(node_addr), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_code(cmd_code), .cmd_from_program(cmd_from_program),
		.cmd_param0(cmd_param0), .cmd_param1(cmd_param1),
		.dev_busy(dev_busy), .clear_status(clear_status), .io_line(io_line),
		.delay_counting(lv[4]), .hold_err(lv[3]), .move_err(lv[2]),
		.over_temp(lv[1]), .traj_active(lv[0]), .ext_index_pulse(idx[2]),
		.int_index_pulse(idx[1]), .sel_index_pulse(idx[0]),
		.status_live(status_live), .status_event(status_event),
		.rsp_valid(rsp_valid),
		.rsp_ready(rsp_ready), .rsp_char(rsp_char), .ack_pulse(ack_pulse),
		.nak_pulse(nak_pulse), .nak_code(nak_code), .protect_en(protect_en),
		.protect_all(protect_all), .first_writable(first_writable),
		.servo_tick(servo_tick), .io_state_word(io_state_word),
		.internal_status_word(internal_status_word));
	src_host src_host_inst (.clk(clk), .cmd_ready(cmd_ready),
		.rsp_valid(rsp_valid), .rsp_char(rsp_char), .ack_pulse(ack_pulse),
		.nak_pulse(nak_pulse), .nak_code(nak_code), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_from_program(cmd_from_program),
		.cmd_param0(cmd_param0), .cmd_param1(cmd_param1),
		.rsp_ready(rsp_ready));
	////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
	endfunction
	function automatic logic [15:0] iow_exp(input logic [2:0] ix);
		return {io_line[7:4], 1'b0, lv[4:2], ~lv[1], io_line[3:1], lv[0], ix};
	endfunction
	task automatic rd(input logic [7:0] code, input logic [15:0] d);
		logic [8:0] r;
		logic [7:0] e[13];
		int k;
		src_host_inst.chars.delete();
		src_host_inst.issue(code, 16'h0000, 16'h0000, 1'b0, r);
		for (k = 0; k < 300 && src_host_inst.chars.size() < 13; k++)
			@(negedge clk);
		e = '{hx(node_addr[7:4]), hx(node_addr[3:0]), 8'h20, 8'h30, 8'h30,
			hx(code[7:4]), hx(code[3:0]), 8'h20, hx(d[15:12]), hx(d[11:8]),
			hx(d[7:4]), hx(d[3:0]), 8'h0d};
		chk(16'(src_host_inst.chars.size()), 16'h000d);
		for (k = 0; k < 13; k++) chk(src_host_inst.chars[k], e[k]);
	endtask
	task automatic prot(input logic [15:0] p0, input logic [15:0] p1,
		input logic busy);
		logic [8:0] r;
		logic [8:0] x;
		@(posedge clk);
		dev_busy <= busy;
		src_host_inst.issue(8'h21, p0, p1, 1'b0, r);
		if (busy) x = 9'h001;
		else if (en && p0 != lock) x = 9'h009;
		else begin
			x = 9'h100;
			en = (p1 != 16'h0000);
			lock = en ? p0 : 16'h0000;
			fw = p1;
		end
		chk(r, x);
		chk(protect_en, en);
		if (en) chk(first_writable, fw);
		chk(protect_all, en && fw == 16'hffff);
	endtask
	task automatic wait_tick();
		@(negedge clk);
		while (!servo_tick) @(negedge clk);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			complete_run();
		end
	end
	initial begin
		logic [8:0] r;
		int i;
		void'($urandom(37));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk(io_state_word, 16'hf0f0);
		prot(16'h04d2, 16'h03e8, 1'b0);
		prot(16'h1111, 16'h0000, 1'b0);
		prot(16'h04d2, 16'hffff, 1'b1);
		prot(16'h04d2, 16'hffff, 1'b0);
		prot(16'h04d2, 16'h0000, 1'b0);
		prot(16'($urandom), 16'($urandom), 1'b0);
		// the third pass offers an undecoded code, refused the same way
		for (i = 0; i < 3; i++) begin
			src_host_inst.issue(8'h15 - 8'(i), 16'h0, 16'h0, 1'b1, r);
			chk(r, 9'h002);
		end
		for (i = 0; i < 5; i++) begin
			@(posedge clk);
			io_line <= 7'($urandom);
			lv <= 5'($urandom);
			node_addr <= 8'($urandom);
			// two sync flops plus one snapshot fit in three periods
			repeat (24) @(posedge clk);
			@(negedge clk);
			chk(io_state_word, iow_exp(3'h0));
			rd(8'h15, iow_exp(3'h0));
		end
		wait_tick();
		@(posedge clk);
		idx <= 3'h7;
		@(posedge clk);
		idx <= 3'h0;
		wait_tick();
		@(negedge clk);
		chk(io_state_word, iow_exp(3'h7));
		wait_tick();
		@(negedge clk);
		chk(io_state_word, iow_exp(3'h0));
		@(posedge clk);
		status_live <= 16'($urandom);
		status_event <= 16'h0101;
		@(posedge clk);
		status_event <= 16'h0000;
		@(posedge clk);
		rd(8'h14, (status_live & 16'h80fe) | 16'h0101);
		@(posedge clk);
		clear_status <= 1'b1;
		@(posedge clk);
		clear_status <= 1'b0;
		rd(8'h14, status_live & 16'h80fe);
		chk(internal_status_word, status_live & 16'h80fe);
		complete_run();
	end
endmodule
bind src_cmd_top src_cmd_assertions #(.SERVO_CLKS(SERVO_CLKS))
	src_cmd_assertions_inst (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .cmd_code(cmd_code),
	.cmd_from_program(cmd_from_program), .cmd_param1(cmd_param1),
	.dev_busy(dev_busy), .clear_status(clear_status),
	.status_event(status_event), .rsp_valid(rsp_valid),
	.ack_pulse(ack_pulse),
	.nak_pulse(nak_pulse), .nak_code(nak_code), .protect_en(protect_en),
	.protect_all(protect_all), .first_writable(first_writable),
	.servo_tick(servo_tick), .io_state_word(io_state_word),
	.internal_status_word(internal_status_word));
